/* src/pvic_ctrl.sv */
// Priority vector interrupt controller top level
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pvic_ctrl #(
  parameter logic [pvic_pkg::NSRC-1:0] SRC_PRESENT = '1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [pvic_pkg::AW-1:0] reg_addr,
  input wire logic [pvic_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pvic_pkg::DW-1:0] reg_rdata,
  input wire logic wdt_pulse,
  input wire logic timer1_pulse,
  input wire logic timer0_pulse,
  input wire logic uart_rx_pulse,
  input wire logic uart_tx_pulse,
  input wire logic adc_pulse,
  input wire logic low_voltage_detect_pulse,
  input wire logic comparator_pulse,
  input wire logic [7:0] port_a_pins,
  input wire logic [3:0] port_c_pins,
  input wire logic trap_osc_primary,
  input wire logic trap_osc_watchdog,
  input wire logic trap_illegal,
  input wire logic cpu_ack,
  input wire logic cpu_enable,
  input wire logic cpu_disable,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic global_request_gate
);
  import pvic_pkg::*;

  pvic_state_t state_reg;
  logic [NSRC-1:0] req_reg;
  logic [NSRC-1:0] req_next;
  logic [2*NSRC-1:0] lvl_reg;
  logic [2*NSRC-1:0] eff_lvl;
  logic [7:0] edge_reg;
  logic gate_reg;
  logic gate_next;
  logic reset_pend_reg;
  logic [2:0] trap_pend_reg;
  logic [SW-1:0] sel_reg;
  logic irq_reg;
  logic [15:0] vector_reg;
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] rdata_next;
  logic [7:0] pa_pulse;
  logic [3:0] pc_pulse;
  logic [NSRC-1:0] src_set;
  logic [NSRC-1:0] req_wmask;
  logic [NSRC-1:0] req_wval;
  logic [NSRC-1:0] req_base;
  logic [NSRC-1:0] ack_clr;
  logic [NSRC-1:0] eligible;
  logic [5:0] win;
  logic [2:0] trap_in;
  logic trap_any;
  logic wdt_win;
  logic cand_valid;
  logic [SW-1:0] cand_sel;
  logic sel_is_src;
  logic offering;
  logic ack_now;
  logic offer_stale;
  logic wr_req0;
  logic wr_req1;
  logic wr_req2;
  logic wr_edge;
  logic wr_ctrl;

  pvic_edge #(
    .N(8),
    .DUAL(1'b0)
  ) u_port_a (
    .clock(clock),
    .rst_b(rst_b),
    .pins(port_a_pins),
    .rise_sel(edge_reg),
    .pulse(pa_pulse)
  );

  pvic_edge #(
    .N(4),
    .DUAL(1'b1)
  ) u_port_c (
    .clock(clock),
    .rst_b(rst_b),
    .pins(port_c_pins),
    .rise_sel(4'h0),
    .pulse(pc_pulse)
  );

  // Gather every request pulse into table order
  always_comb
  begin
    src_set = '0;
    src_set[SRC_WDT] = wdt_pulse;
    src_set[SRC_T1] = timer1_pulse;
    src_set[SRC_T0] = timer0_pulse;
    src_set[SRC_URX] = uart_rx_pulse;
    src_set[SRC_UTX] = uart_tx_pulse;
    src_set[SRC_ADC] = adc_pulse;
    src_set[SRC_PA7] = pa_pulse[7];
    src_set[SRC_LVD] = low_voltage_detect_pulse;
    src_set[SRC_PA6] = pa_pulse[6];
    src_set[SRC_CMP] = comparator_pulse;
    for (int p = 0; p < 6; p++)
      src_set[SRC_PA0_TOP - p] = pa_pulse[p];
    for (int p = 0; p < 4; p++)
      src_set[SRC_PC0_TOP - p] = pc_pulse[p];
  end

  // Register decode
  assign wr_req0 = reg_wr && reg_addr == OFS_REQ0;
  assign wr_req1 = reg_wr && reg_addr == OFS_REQ1;
  assign wr_req2 = reg_wr && reg_addr == OFS_REQ2;
  assign wr_edge = reg_wr && reg_addr == OFS_EDGE;
  assign wr_ctrl = reg_wr && reg_addr == OFS_CTRL;

  assign offering = state_reg == PVIC_OFFER;
  assign ack_now = offering && cpu_ack;
  assign sel_is_src = sel_reg < SW'(NSRC);
  assign ack_clr = (ack_now && sel_is_src) ?
    ({{(NSRC-1){1'b0}}, 1'b1} << sel_reg) : '0;

  // Pending bits: a new pulse beats a clear in the same cycle
  assign req_wmask = {{4{wr_req2}}, {8{wr_req1}}, {8{wr_req0}}};
  assign req_wval = {reg_wdata[3:0], reg_wdata, reg_wdata};
  assign req_base = (req_reg & ~req_wmask) | (req_wval & req_wmask);
  assign req_next = ((req_base & ~ack_clr) | src_set) &
                    SRC_PRESENT;

  // Watchdog runs at the top level whenever it is enabled
  always_comb
  begin
    eff_lvl = lvl_reg;
    if (lvl_reg[2*SRC_WDT +: 2] != LVL_OFF)
      eff_lvl[2*SRC_WDT +: 2] = LVL_TOP;
  end

  // Higher level wins, then lower index within a level
  function automatic logic [5:0] pick(input logic [NSRC-1:0] p,
                                      input logic [2*NSRC-1:0] l);
    logic [5:0] r;
    r = '0;
    for (int lv = 1; lv <= 3; lv++)
      for (int i = NSRC - 1; i >= 0; i--)
        if (p[i] && l[2*i +: 2] == 2'(lv))
          r = {1'b1, 5'(i)};
    return r;
  endfunction

  // Without the gate nothing maskable is offered: polled mode
  assign eligible = gate_reg ? req_reg : '0;
  assign win = pick(eligible, eff_lvl);
  assign wdt_win = win[5] && win[4:0] == SRC_WDT;
  assign cand_valid = reset_pend_reg || win[5] || (|trap_pend_reg);
  // Reset, watchdog, oscillator traps, illegal trap, then sources
  assign cand_sel = reset_pend_reg ? SEL_RST :
                    wdt_win ? SRC_WDT :
                    trap_pend_reg[0] ? SEL_OSCP :
                    trap_pend_reg[1] ? SEL_OSCW :
                    trap_pend_reg[2] ? SEL_ILL :
                    win[4:0];
  assign offer_stale = sel_is_src && (!gate_reg || !req_reg[sel_reg]);

  assign trap_in = {trap_illegal, trap_osc_watchdog, trap_osc_primary};
  assign trap_any = |trap_in;

  // Global gate: trap, acknowledge and disable clears take precedence over enable and writes
  assign gate_next = trap_any ? 1'b0 :
                     (ack_now && sel_is_src) ? 1'b0 :
                     cpu_disable ? 1'b0 :
                     cpu_enable ? 1'b1 :
                     wr_ctrl ? reg_wdata[CTRL_GATE_BIT] :
                     gate_reg;

  assign rdata_next = !reg_rd ? '0 :
    reg_addr == OFS_REQ0 ? req_reg[7:0] :
    reg_addr == OFS_REQ1 ? req_reg[15:8] :
    reg_addr == OFS_REQ2 ? {4'h0, req_reg[19:16]} :
    (reg_addr >= OFS_LVL0 && reg_addr < OFS_LVL0 + 8'(NLVL_REG)) ?
      lvl_reg[8*(reg_addr - OFS_LVL0) +: 8] :
    reg_addr == OFS_EDGE ? edge_reg :
    reg_addr == OFS_CTRL ? {gate_reg, 7'h00} :
    reg_addr == OFS_STAT ? {offering, 2'h0, sel_reg} :
    '0;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      req_reg <= '0;
      lvl_reg <= RST_LVL;
      edge_reg <= RST_EDGE;
      gate_reg <= 1'b0;
      rdata_reg <= '0;
      trap_pend_reg <= '0;
    end
    else
    begin
      req_reg <= req_next;
      gate_reg <= gate_next;
      rdata_reg <= rdata_next;
      if (wr_edge)
        edge_reg <= reg_wdata;
      for (int k = 0; k < NLVL_REG; k++)
        if (reg_wr && reg_addr == OFS_LVL0 + 8'(k))
          lvl_reg[8*k +: 8] <= reg_wdata;
      for (int t = 0; t < 3; t++)
        if (trap_in[t])
          trap_pend_reg[t] <= 1'b1;
        else if (ack_now && sel_reg == SEL_OSCP + 5'(t))
          trap_pend_reg[t] <= 1'b0;
    end
  end

  // Offer handshake toward the processor
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state_reg <= PVIC_IDLE;
      reset_pend_reg <= 1'b1;
      sel_reg <= '0;
      irq_reg <= 1'b0;
      vector_reg <= '0;
    end
    else
    begin
      case (state_reg)
        PVIC_IDLE:
        begin
          if (cand_valid)
          begin
            state_reg <= PVIC_OFFER;
            sel_reg <= cand_sel;
            irq_reg <= 1'b1;
            vector_reg <= pvic_vector(cand_sel);
          end
        end
        PVIC_OFFER:
        begin
          if (cpu_ack)
          begin
            state_reg <= PVIC_IDLE;
            irq_reg <= 1'b0;
            if (sel_reg == SEL_RST)
              reset_pend_reg <= 1'b0;
          end
          else if (offer_stale)
          begin
            state_reg <= PVIC_IDLE;
            irq_reg <= 1'b0;
          end
        end
        default:
          state_reg <= PVIC_IDLE;
      endcase
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq_req = irq_reg;
  assign irq_vector = vector_reg;
  assign global_request_gate = gate_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  property p_vec_stable;
    irq_req && $past(irq_req) |-> $stable(irq_vector);
  endproperty
  a_vec_stable: assert property (p_vec_stable)
    else $error("vector changed while offered");

  property p_no_reserved;
    irq_req |-> !pvic_reserved(irq_vector);
  endproperty
  a_no_reserved: assert property (p_no_reserved)
    else $error("reserved vector offered");

  property p_polled;
    !gate_reg && !offering |=> !(irq_req && sel_is_src);
  endproperty
  a_polled: assert property (p_polled)
    else $error("maskable source offered with gate clear");

  property p_ack_gate;
    ack_now && sel_is_src |=> !gate_reg;
  endproperty
  a_ack_gate: assert property (p_ack_gate)
    else $error("gate not cleared by acknowledge");

  property p_trap_gate;
    trap_any |=> !gate_reg ##1 trap_pend_reg != 3'h0 || offering;
  endproperty
  a_trap_gate: assert property (p_trap_gate)
    else $error("trap did not clear gate or stay pending");

  property p_pulse_sets;
    timer1_pulse |=> req_reg[SRC_T1];
  endproperty
  a_pulse_sets: assert property (p_pulse_sets)
    else $error("timer 1 pulse not latched");

  property p_ack_clears;
    ack_now && sel_is_src && !src_set[sel_reg] && !reg_wr
      |=> !req_reg[$past(sel_reg)];
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("pending bit survived acknowledge");

  property p_reset_first;
    $rose(rst_b) |=> irq_req && irq_vector == VEC_RESET;
  endproperty
  a_reset_first: assert property (p_reset_first)
    else $error("reset vector not offered first");

  property p_wdt_top;
    !offering && !reset_pend_reg && gate_reg && req_reg[SRC_WDT] &&
      lvl_reg[2*SRC_WDT +: 2] != LVL_OFF |=> irq_vector == VEC_WDT;
  endproperty
  a_wdt_top: assert property (p_wdt_top)
    else $error("watchdog not ranked below reset only");

  property p_osc_rank;
    !offering && !reset_pend_reg && !wdt_win && trap_pend_reg[0]
      |=> irq_vector == VEC_OSCP;
  endproperty
  a_osc_rank: assert property (p_osc_rank)
    else $error("oscillator trap not ranked above others");
endmodule
`default_nettype wire

/* src/pvic_pkg.sv */
// Package: constants for the priority vector interrupt controller
// Operation
// - 20 sources mapped onto 18 vector slots
// - Twelve port pin sources, two shared slots
// - Eight peripheral sources, two shared slots
// - Eight selectable-edge pins, four dual-edge pins
// - Per-source priority from three levels
// - Watchdog and low-voltage detect can interrupt
// - Polled mode leaves processor execution alone
// - Accepted request diverts, services, then resumes
// - Vector word: high byte even address
// - Fixed order: reset first, then peripherals
// - Watchdog at 0x0004 just below reset
// - Oscillator fail traps at 0x003a, 0x003c
// - Illegal instruction trap at 0x0006
// - 0x0018 shared: port A pin 7, low voltage
// - 0x001a shared: port A pin 6, comparator
// - Port A pins 5..0 at 0x001c..0x0026
// - Port C pins 3..0 at 0x0030..0x0036
// - Absent sources on smaller parts removed
// - Level first, then table order; traps below reset and watchdog only
// - One-cycle request pulses; acknowledge clears pending
// - Global gate set and cleared by listed events
package pvic_pkg;
  localparam int NSRC = 20;
  localparam int AW = 8;
  localparam int DW = 8;
  localparam int SW = 5;
  // Register offsets
  localparam logic [7:0] OFS_REQ0 = 8'h00;
  localparam logic [7:0] OFS_REQ1 = 8'h01;
  localparam logic [7:0] OFS_REQ2 = 8'h02;
  localparam logic [7:0] OFS_LVL0 = 8'h03;
  localparam logic [7:0] OFS_EDGE = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h09;
  localparam logic [7:0] OFS_STAT = 8'h0a;
  localparam int NLVL_REG = 5;
  localparam int CTRL_GATE_BIT = 7;
  localparam int STAT_OFFER_BIT = 7;
  localparam logic [7:0] RST_EDGE = 8'h00;
  localparam logic [2*NSRC-1:0] RST_LVL = '0;
  localparam logic [1:0] LVL_OFF = 2'h0;
  localparam logic [1:0] LVL_TOP = 2'h3;
  // Source indices in table order
  localparam logic [4:0] SRC_WDT = 5'h00;
  localparam logic [4:0] SRC_T1 = 5'h01;
  localparam logic [4:0] SRC_T0 = 5'h02;
  localparam logic [4:0] SRC_URX = 5'h03;
  localparam logic [4:0] SRC_UTX = 5'h04;
  localparam logic [4:0] SRC_ADC = 5'h05;
  localparam logic [4:0] SRC_PA7 = 5'h06;
  localparam logic [4:0] SRC_LVD = 5'h07;
  localparam logic [4:0] SRC_PA6 = 5'h08;
  localparam logic [4:0] SRC_CMP = 5'h09;
  localparam int SRC_PA0_TOP = 15;
  localparam int SRC_PC0_TOP = 19;
  // Selection codes beyond the sources
  localparam logic [4:0] SEL_RST = 5'h14;
  localparam logic [4:0] SEL_OSCP = 5'h15;
  localparam logic [4:0] SEL_OSCW = 5'h16;
  localparam logic [4:0] SEL_ILL = 5'h17;
  localparam logic [15:0] VEC_RESET = 16'h0002;
  localparam logic [15:0] VEC_WDT = 16'h0004;
  localparam logic [15:0] VEC_OSCP = 16'h003a;
  localparam logic [15:0] VEC_OSCW = 16'h003c;
  localparam logic [15:0] VEC_ILL = 16'h0006;
  localparam logic [15:0] VEC_PA_BASE = 16'h001c;
  localparam logic [15:0] VEC_PC_BASE = 16'h0030;

  typedef enum logic {PVIC_IDLE, PVIC_OFFER} pvic_state_t;

  function automatic logic [15:0] pvic_vector(input logic [4:0] sel);
    logic [15:0] v;
    v = VEC_RESET;
    case (sel)
      SRC_WDT: v = VEC_WDT;
      SRC_T1: v = 16'h000a;
      SRC_T0: v = 16'h000c;
      SRC_URX: v = 16'h000e;
      SRC_UTX: v = 16'h0010;
      SRC_ADC: v = 16'h0016;
      SRC_PA7, SRC_LVD: v = 16'h0018;
      SRC_PA6, SRC_CMP: v = 16'h001a;
      SEL_OSCP: v = VEC_OSCP;
      SEL_OSCW: v = VEC_OSCW;
      SEL_ILL: v = VEC_ILL;
      SEL_RST: v = VEC_RESET;
      default:
      begin
        if (sel <= 5'(SRC_PA0_TOP))
          v = VEC_PA_BASE + {10'h000, sel - 5'h0a, 1'b0};
        else
          v = VEC_PC_BASE + {10'h000, sel - 5'h10, 1'b0};
      end
    endcase
    return v;
  endfunction

  function automatic logic pvic_reserved(input logic [15:0] v);
    return v == 16'h0008 || v == 16'h0012 || v == 16'h0014 ||
           (v >= 16'h0028 && v <= 16'h002e) || v == 16'h0038;
  endfunction
endpackage

/* src/pvic_edge.sv */
// Edge detector turning port pin transitions into one-cycle requests
`timescale 1ns/1ps
`default_nettype none
module pvic_edge #(
  parameter int N = 8,
  parameter bit DUAL = 1'b0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [N-1:0] pins,
  input wire logic [N-1:0] rise_sel,
  output logic [N-1:0] pulse
);
  logic [N-1:0] prev_reg;
  logic [N-1:0] pulse_reg;
  logic primed_reg;
  logic [N-1:0] hit;
  genvar g;

  generate
    for (g = 0; g < N; g++)
    begin : g_pin
      // Dual-edge pins fire on any change, others on the chosen edge
      assign hit[g] = DUAL ? (pins[g] ^ prev_reg[g]) :
        (rise_sel[g] ? (pins[g] & ~prev_reg[g]) :
                       (~pins[g] & prev_reg[g]));
    end
  endgenerate

  // First sample after reset only primes, so no false edge
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      prev_reg <= '0;
      primed_reg <= 1'b0;
      pulse_reg <= '0;
    end
    else
    begin
      prev_reg <= pins;
      primed_reg <= 1'b1;
      pulse_reg <= primed_reg ? hit : '0;
    end
  end

  assign pulse = pulse_reg;
endmodule
`default_nettype wire

/* test/pvic_cpu_model.sv */
// Processor core model that takes offered vectors and later resumes
`timescale 1ns/1ps
`default_nettype none
module pvic_cpu_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic ack_on,
  input wire logic ret_on,
  input wire logic [3:0] ack_wait,
  output logic cpu_ack,
  output logic cpu_enable,
  output logic [15:0] taken_vector,
  output logic [7:0] taken_count
);
  logic [3:0] wait_reg;
  logic [2:0] ret_reg;
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      cpu_ack <= 1'b0;
      cpu_enable <= 1'b0;
      taken_vector <= 16'h0000;
      taken_count <= 8'h00;
      wait_reg <= 4'h0;
      ret_reg <= 3'h0;
    end
    else
    begin
      cpu_ack <= 1'b0;
      cpu_enable <= 1'b0;
      // Return from service re-opens the gate
      if (ret_reg != 3'h0)
      begin
        ret_reg <= ret_reg - 3'h1;
        cpu_enable <= ret_on && ret_reg == 3'h1;
      end
      if (!irq_req || cpu_ack)
        wait_reg <= 4'h0;
      else if (ack_on && wait_reg == ack_wait)
      begin
        cpu_ack <= 1'b1;
        // Whole vector word copied from irq_vector in the acknowledge cycle
        taken_vector <= irq_vector;
        taken_count <= taken_count + 8'h01;
        ret_reg <= 3'h4;
      end
      else if (ack_on)
        wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the priority vector interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pvic_pkg::*;
  logic clock, rst_b, reg_wr, reg_rd, cpu_disable, ack_on, ret_on;
  logic irq_req, gate, cpu_ack, cpu_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, periph, port_a;
  logic [7:0] taken_count, got;
  logic [3:0] port_c, ack_wait;
  logic [2:0] trap;
  logic [15:0] irq_vector, taken_vector;
  int compares = 0;
  int miscompares = 0;

  pvic_ctrl u_dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wdt_pulse(periph[0]),
    .timer1_pulse(periph[1]), .timer0_pulse(periph[2]),
    .uart_rx_pulse(periph[3]), .uart_tx_pulse(periph[4]),
    .adc_pulse(periph[5]), .low_voltage_detect_pulse(periph[6]),
    .comparator_pulse(periph[7]), .port_a_pins(port_a),
    .port_c_pins(port_c), .trap_osc_primary(trap[0]),
    .trap_osc_watchdog(trap[1]), .trap_illegal(trap[2]),
    .cpu_ack(cpu_ack), .cpu_enable(cpu_enable),
    .cpu_disable(cpu_disable), .irq_req(irq_req),
    .irq_vector(irq_vector), .global_request_gate(gate));

  pvic_cpu_model u_cpu (.clock(clock), .rst_b(rst_b), .irq_req(irq_req),
    .irq_vector(irq_vector), .ack_on(ack_on), .ret_on(ret_on),
    .ack_wait(ack_wait), .cpu_ack(cpu_ack), .cpu_enable(cpu_enable),
    .taken_vector(taken_vector), .taken_count(taken_count));

  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask

  task automatic fire(input logic [7:0] p, input logic [2:0] t);
    @(posedge clock);
    periph <= p;
    trap <= t;
    @(posedge clock);
    periph <= 8'h00;
    trap <= 3'h0;
  endtask

  task automatic shut;
    @(posedge clock);
    cpu_disable <= 1'b1;
    @(posedge clock);
    cpu_disable <= 1'b0;
  endtask

  task automatic levels(input logic [7:0] v);
    for (int k = 0; k < 5; k++)
      wr(OFS_LVL0 + 8'(k), v);
  endtask

  // Waits for the next vector the processor takes
  task automatic take(input logic [15:0] exp);
    int n;
    n = 0;
    while (taken_count === got && n < 300)
    begin
      @(negedge clock);
      n++;
    end
    if (taken_count === got)
    begin
      miscompares++;
      complete_run();
    end
    got = taken_count;
    check("taken vector", taken_vector, exp);
  endtask

  task automatic t_reset;
    logic [7:0] d;
    take(16'h0002);
    check("gate", {15'h0000, gate}, 16'h0000);
    rd(OFS_CTRL, d);
    check("ctrl", {8'h00, d}, 16'h0000);
    rd(OFS_EDGE, d);
    check("edge", {8'h00, d}, 16'h0000);
    wr(8'h3f, 8'hff);
    rd(8'h3f, d);
    check("unmapped", {8'h00, d}, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_vectors;
    logic [15:0] tbl [8];
    tbl = '{16'h0004, 16'h000a, 16'h000c, 16'h000e, 16'h0010, 16'h0016,
            16'h0018, 16'h001a};
    ret_on <= 1'b1;
    levels(8'h55);
    wr(OFS_CTRL, 8'h80);
    for (int i = 0; i < 8; i++)
    begin
      ack_wait <= 4'(i);
      fire(8'h01 << i, 3'h0);
      take(tbl[i]);
    end
    ack_wait <= 4'h0;
    $display("test vectors done");
  endtask

  task automatic t_pins;
    logic [15:0] v;
    wr(OFS_EDGE, 8'hff);
    for (int p = 7; p >= 0; p--)
    begin
      v = p == 7 ? 16'h0018 : p == 6 ? 16'h001a : 16'h001c + 16'(2 * (5 - p));
      @(posedge clock);
      port_a[p] <= 1'b1;
      take(v);
    end
    @(posedge clock);
    port_a <= 8'h00;
    repeat (12) @(negedge clock);
    check("falling ignored", {8'h00, taken_count}, {8'h00, got});
    for (int p = 3; p >= 0; p--)
    begin
      v = 16'h0030 + 16'(2 * (3 - p));
      @(posedge clock);
      port_c[p] <= 1'b1;
      take(v);
      @(posedge clock);
      port_c[p] <= 1'b0;
      take(v);
    end
    $display("test pins done");
  endtask

  task automatic t_priority;
    logic [7:0] d;
    ret_on <= 1'b0;
    shut();
    levels(8'h00);
    wr(OFS_LVL0, 8'h04);
    wr(OFS_LVL0 + 8'h04, 8'hc0);
    @(posedge clock);
    port_c[0] <= 1'b1;
    fire(8'h02, 3'h0);
    repeat (4) @(negedge clock);
    check("polled offer", {15'h0000, irq_req}, 16'h0000);
    rd(OFS_REQ0, d);
    check("pending low", {8'h00, d}, 16'h0002);
    rd(OFS_REQ2, d);
    check("pending high", {8'h00, d}, 16'h0008);
    // Last offer was port C pin 0, nothing offered since
    rd(OFS_STAT, d);
    check("status", {8'h00, d}, 16'h0013);
    wr(OFS_CTRL, 8'h80);
    take(16'h0036);
    // Acknowledge reaches the gate one edge after it is taken
    @(negedge clock);
    check("gate after ack", {15'h0000, gate}, 16'h0000);
    wr(OFS_CTRL, 8'h80);
    take(16'h000a);
    levels(8'haa);
    ret_on <= 1'b1;
    fire(8'h94, 3'h0);
    wr(OFS_CTRL, 8'h80);
    take(16'h000c);
    take(16'h0010);
    take(16'h001a);
    ret_on <= 1'b0;
    repeat (6) @(posedge clock);
    shut();
    wr(OFS_REQ0, 8'h08);
    rd(OFS_REQ0, d);
    check("soft request", {8'h00, d}, 16'h0008);
    wr(OFS_REQ0, 8'h00);
    wr(OFS_CTRL, 8'h80);
    repeat (8) @(negedge clock);
    check("cleared request", {8'h00, taken_count}, {8'h00, got});
    $display("test priority done");
  endtask

  task automatic t_traps;
    fire(8'h00, 3'h7);
    take(16'h003a);
    take(16'h003c);
    take(16'h0006);
    check("gate after trap", {15'h0000, gate}, 16'h0000);
    $display("test traps done");
  endtask

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial
  begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    periph = 8'h00;
    trap = 3'h0;
    port_a = 8'h00;
    port_c = 4'h0;
    cpu_disable = 1'b0;
    ack_on = 1'b1;
    ret_on = 1'b0;
    ack_wait = 4'h0;
    got = 8'h00;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    t_reset();
    t_vectors();
    t_pins();
    t_priority();
    t_traps();
    complete_run();
  end
endmodule
`default_nettype wire
